// [common/status_pkg.sv]
// constants, command kinds and carrier structs for the status event hierarchy
// assumes one 40 MHz clock shared by the command parser and this block
`default_nettype none
package status_pkg;
    localparam int          PART_W      = 16;     // width of every register part
    localparam int          LVL_W       = 15;     // live bits; bit 15 always reads zero
    localparam int          NUM_SCPI    = 2;      // operation and questionable registers
    localparam logic [1:0]  SEL_OPER    = 2'h0;   // operation register
    localparam logic [1:0]  SEL_QUES    = 2'h1;   // questionable register
    localparam logic [1:0]  SEL_COMMON  = 2'h2;   // status byte and its companions
    localparam logic [2:0]  PART_LEVEL  = 3'h0;   // live level part
    localparam logic [2:0]  PART_RISE   = 3'h1;   // rise_filter part
    localparam logic [2:0]  PART_FALL   = 3'h2;   // fall_filter part
    localparam logic [2:0]  PART_EVENT  = 3'h3;   // latched_events part
    localparam logic [2:0]  PART_MASK   = 3'h4;   // summary_mask part
    localparam logic [2:0]  PART_STB    = 3'h0;   // status byte
    localparam logic [2:0]  PART_SRE    = 3'h1;   // service request enable
    localparam logic [2:0]  PART_ESR    = 3'h2;   // standard event register
    localparam logic [2:0]  PART_ESE    = 3'h3;   // standard event enable
    localparam logic [2:0]  PART_PPE    = 3'h4;   // parallel poll enable
    localparam logic [2:0]  PART_IST    = 3'h5;   // individual status flag
    localparam int          ESR_OPC_BIT = 0;      // operation complete
    localparam int          STB_ERRQ    = 2;      // error queue not empty
    localparam int          STB_QUES    = 3;      // questionable summary
    localparam int          STB_MAV     = 4;      // message available
    localparam int          STB_ESB     = 5;      // standard event summary
    localparam int          STB_MSS     = 6;      // master summary
    localparam int          STB_OPER    = 7;      // operation summary
    localparam int          OPER_WTRIG  = 3;      // waiting for trigger, operation register
    localparam logic [15:0] PART_RST    = 16'h0000; // reset value of every part
    localparam logic [7:0]  BYTE_RST    = 8'h00;  // reset value of every byte register
    localparam logic [7:0]  SRE_USE     = 8'hbf;  // request enable bit 6 never counts

    typedef enum logic [1:0] {
        CMD_PLAIN,                                // ordinary command, may overlap
        CMD_OPC,                                  // operation complete command
        CMD_OPC_QUERY,                            // operation complete query
        CMD_WAIT                                  // wait command
    } cmd_kind_t;

    typedef struct packed {
        logic        valid;                       // access strobe, one cycle
        logic        write;                       // 1 write, 0 read
        logic [1:0]  sel;                         // which register
        logic [2:0]  part;                        // which part
        logic [15:0] wdata;                       // write data
    } reg_req_t;

    typedef struct packed {
        logic        ack;                         // answer strobe
        logic [15:0] rdata;                       // read data
    } reg_rsp_t;

    typedef struct packed {
        logic      valid;                         // command offered
        cmd_kind_t kind;                          // its kind
    } cmd_req_t;
endpackage : status_pkg
`default_nettype wire

// [design/status_event_hierarchy.sv]
// status event hierarchy: two five-part registers, standard events, status byte
// assumes the command parser drives reg_req, cmd and exec_idle on clk; hw levels are async
// Operation
// - five 16-bit parts, one bit per condition
// - bit 15 of every part reads zero
// - level part follows hardware, read-only
// - rising edge latches event when rise filter set
// - falling edge latches event when fall filter set
// - filters and mask freely read and written
// - event part read-only, cleared by read
// - summary is OR of events ANDed with mask
// - summary feeds a level bit above
// - status byte from masked events and summaries
// - individual status flag masked by poll register
// - message available follows output buffer
// - operation complete after prior commands finish
// - completion query stalls, answers one when done
// - wait command holds later commands back
// - plain commands may overlap
// - operation bit 3 means waiting for trigger
// - registers readable over either remote link
// - bit 6 summary, request on enabled rise
// - flag ORs status byte bits ANDed with poll mask
// - message available sits at bit 4
`default_nettype none
module status_event_hierarchy (
    input  wire  logic                clk,           // 40 MHz clock
    input  wire  logic                resetn,        // async reset, active low
    input  wire  status_pkg::reg_req_t reg_req,      // register access from the parser
    output var   status_pkg::reg_rsp_t reg_rsp,      // register answer
    input  wire  logic [14:0]         oper_hw,       // operation levels, bit 3 waits trigger
    input  wire  logic [14:0]         ques_hw,       // questionable levels
    input  wire  logic [7:1]          esr_evt,       // standard event pulses, bits 7..1
    input  wire  logic                err_nonempty,  // error queue holds an entry
    input  wire  logic                msg_avail,     // output buffer holds a message
    input  wire  logic                exec_idle,     // every accepted command finished
    input  wire  status_pkg::cmd_req_t cmd,          // command offered for execution
    output logic                      cmd_ready,     // command may be taken
    output logic                      opc_reply,     // completion query answers one
    output logic                      srq,           // service request pulse
    output logic                      ist            // individual status flag
);
    // per-register state, kept outside the loop so the read mux can see it
    logic [14:0] hw_in    [status_pkg::NUM_SCPI];    // raw pin levels
    logic [14:0] sync1_q  [status_pkg::NUM_SCPI];    // first synchroniser stage
    logic [14:0] lvl_q    [status_pkg::NUM_SCPI];    // level part
    logic [14:0] prev_q   [status_pkg::NUM_SCPI];    // level one cycle ago
    logic [15:0] rise_q   [status_pkg::NUM_SCPI];    // rise filter part
    logic [15:0] fall_q   [status_pkg::NUM_SCPI];    // fall filter part
    logic [15:0] ev_q     [status_pkg::NUM_SCPI];    // latched event part
    logic [15:0] mask_q   [status_pkg::NUM_SCPI];    // summary mask part
    logic [14:0] edges    [status_pkg::NUM_SCPI];    // filtered transitions this cycle
    logic [1:0]  sum;                                // summary bit per register

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    assign hw_in[0] = oper_hw;
    assign hw_in[1] = ques_hw;

    // one identical five-part register per index
    for (genvar g = 0; g < status_pkg::NUM_SCPI; g++) begin : g_reg
        logic [15:0] rise_d;                         // next rise filter
        logic [15:0] fall_d;                         // next fall filter
        logic [15:0] ev_d;                           // next event part
        logic [15:0] mask_d;                         // next mask
        logic        wr_hit;                         // write to this register
        logic        rd_clear;                       // read of this event part

        // edge filters, read clear and writes; the level part takes no write
        always_comb begin
            wr_hit   = reg_req.valid & reg_req.write & (reg_req.sel == 2'(g));
            rd_clear = reg_req.valid & ~reg_req.write & (reg_req.sel == 2'(g))
                     & (reg_req.part == status_pkg::PART_EVENT);
            edges[g] = (rise_q[g][14:0] & lvl_q[g] & ~prev_q[g])
                     | (fall_q[g][14:0] & ~lvl_q[g] & prev_q[g]);
            rise_d   = rise_q[g];
            fall_d   = fall_q[g];
            mask_d   = mask_q[g];
            if (wr_hit && reg_req.part == status_pkg::PART_RISE) begin
                rise_d = {1'b0, reg_req.wdata[14:0]};
            end
            if (wr_hit && reg_req.part == status_pkg::PART_FALL) begin
                fall_d = {1'b0, reg_req.wdata[14:0]};
            end
            if (wr_hit && reg_req.part == status_pkg::PART_MASK) begin
                mask_d = {1'b0, reg_req.wdata[14:0]};
            end
            // the clear only removes what was there; new edges still land
            ev_d = rd_clear ? status_pkg::PART_RST : ev_q[g];
            ev_d = ev_d | {1'b0, edges[g]};
        end

        // registers; the level path is a plain two-stage synchroniser
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                sync1_q[g] <= 15'h0000;
                lvl_q[g]   <= 15'h0000;
                prev_q[g]  <= 15'h0000;
                rise_q[g]  <= status_pkg::PART_RST;
                fall_q[g]  <= status_pkg::PART_RST;
                ev_q[g]    <= status_pkg::PART_RST;
                mask_q[g]  <= status_pkg::PART_RST;
            end else begin
                sync1_q[g] <= hw_in[g];
                lvl_q[g]   <= sync1_q[g];
                prev_q[g]  <= lvl_q[g];
                rise_q[g]  <= rise_d;
                fall_q[g]  <= fall_d;
                ev_q[g]    <= ev_d;
                mask_q[g]  <= mask_d;
            end
        end

        assign sum[g] = |(ev_q[g] & mask_q[g]);

        a_edge_latch: assert property (1 |=> (ev_q[g][14:0] & $past(edges[g])) == $past(edges[g]))
            else $error("filtered transition not latched");
        a_no_stray: assert property (1 |=> (ev_q[g][14:0] & ~$past(ev_q[g][14:0])
                                            & ~$past(edges[g])) == 15'h0000)
            else $error("event bit set without filtered edge");
        a_read_clear: assert property (rd_clear |=> ev_q[g][14:0] == $past(edges[g]))
            else $error("read did not clear events or lost a new one");
    end

    // standard event, enables, status byte and the synchronisation machine
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_OPCQ} sync_state_t;
    sync_state_t state_q;                            // synchronisation state
    sync_state_t state_d;                            // next state
    logic [7:0]  esr_q, esr_d;                       // standard event register
    logic [7:0]  ese_q, ese_d;                       // standard event enable
    logic [7:0]  sre_q, sre_d;                       // service request enable
    logic [7:0]  ppe_q, ppe_d;                       // parallel poll enable
    logic [7:0]  stb_q, stb_d;                       // status byte
    logic [7:0]  base_d;                             // status byte without bit 6
    logic        opc_pend_q, opc_pend_d;             // completion command outstanding
    logic        opc_set;                            // operation complete fires
    logic        accept;                             // command taken this cycle
    logic        cwr, crd;                           // common register write or read
    logic        ready_q, ready_d;                   // command ready
    logic        reply_q, reply_d;                   // query answer pulse
    logic        srq_q, srq_d;                       // service request pulse
    logic        ist_q, ist_d;                       // individual status flag
    status_pkg::reg_rsp_t rsp_q, rsp_d;              // register answer

    always_comb begin
        accept  = cmd.valid & ready_q;
        cwr     = reg_req.valid & reg_req.write & (reg_req.sel == status_pkg::SEL_COMMON);
        crd     = reg_req.valid & ~reg_req.write & (reg_req.sel == status_pkg::SEL_COMMON);
        state_d = state_q;
        reply_d = 1'b0;
        opc_set = 1'b0;
        opc_pend_d = opc_pend_q;
        // plain commands are taken back to back and run overlapped
        case (state_q)
            ST_IDLE: begin
                if (accept && cmd.kind == status_pkg::CMD_OPC) begin
                    opc_pend_d = 1'b1;
                end
                if (accept && cmd.kind == status_pkg::CMD_WAIT) begin
                    state_d = ST_WAIT;
                end
                if (accept && cmd.kind == status_pkg::CMD_OPC_QUERY) begin
                    state_d = ST_OPCQ;
                end
            end
            ST_WAIT: begin
                if (exec_idle) begin
                    state_d = ST_IDLE;
                end
            end
            ST_OPCQ: begin
                if (exec_idle) begin
                    opc_set = 1'b1;
                    reply_d = 1'b1;
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // pending check runs a cycle after acceptance so exec_idle has seen it
        if (opc_pend_q && exec_idle) begin
            opc_set    = 1'b1;
            opc_pend_d = 1'b0;
        end
        ready_d = (state_d == ST_IDLE);
        // byte registers; set beats the read clear
        ese_d = ese_q;
        sre_d = sre_q;
        ppe_d = ppe_q;
        if (cwr && reg_req.part == status_pkg::PART_ESE) ese_d = reg_req.wdata[7:0];
        if (cwr && reg_req.part == status_pkg::PART_SRE) sre_d = reg_req.wdata[7:0];
        if (cwr && reg_req.part == status_pkg::PART_PPE) ppe_d = reg_req.wdata[7:0];
        esr_d = (crd && reg_req.part == status_pkg::PART_ESR) ? status_pkg::BYTE_RST : esr_q;
        esr_d = esr_d | {esr_evt, opc_set};
        // summaries climb into the status byte
        base_d = status_pkg::BYTE_RST;
        base_d[status_pkg::STB_ERRQ] = err_nonempty;
        base_d[status_pkg::STB_QUES] = sum[1];
        base_d[status_pkg::STB_MAV]  = msg_avail;
        base_d[status_pkg::STB_ESB]  = |(esr_q & ese_q);
        base_d[status_pkg::STB_OPER] = sum[0];
        stb_d = base_d;
        stb_d[status_pkg::STB_MSS] = |(base_d & sre_q & status_pkg::SRE_USE);
        srq_d = |(base_d & ~stb_q & sre_q & status_pkg::SRE_USE);
        ist_d = |(stb_d & ppe_q);
        // answers; unused selections and parts read zero
        rsp_d.ack   = reg_req.valid;
        rsp_d.rdata = status_pkg::PART_RST;
        if (reg_req.valid && !reg_req.write && reg_req.sel != status_pkg::SEL_COMMON
            && reg_req.sel[1] == 1'b0) begin
            case (reg_req.part)
                status_pkg::PART_LEVEL: rsp_d.rdata = {1'b0, lvl_q[reg_req.sel[0]]};
                status_pkg::PART_RISE:  rsp_d.rdata = rise_q[reg_req.sel[0]];
                status_pkg::PART_FALL:  rsp_d.rdata = fall_q[reg_req.sel[0]];
                status_pkg::PART_EVENT: rsp_d.rdata = ev_q[reg_req.sel[0]];
                status_pkg::PART_MASK:  rsp_d.rdata = mask_q[reg_req.sel[0]];
                default:                rsp_d.rdata = status_pkg::PART_RST;
            endcase
        end
        if (crd) begin
            case (reg_req.part)
                status_pkg::PART_STB: rsp_d.rdata = {8'h00, stb_q};
                status_pkg::PART_SRE: rsp_d.rdata = {8'h00, sre_q};
                status_pkg::PART_ESR: rsp_d.rdata = {8'h00, esr_q};
                status_pkg::PART_ESE: rsp_d.rdata = {8'h00, ese_q};
                status_pkg::PART_PPE: rsp_d.rdata = {8'h00, ppe_q};
                status_pkg::PART_IST: rsp_d.rdata = {15'h0000, ist_q};
                default:              rsp_d.rdata = status_pkg::PART_RST;
            endcase
        end
    end

    // registers of the upper level; every output is one of these flops
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q    <= ST_IDLE;
            esr_q      <= status_pkg::BYTE_RST;
            ese_q      <= status_pkg::BYTE_RST;
            sre_q      <= status_pkg::BYTE_RST;
            ppe_q      <= status_pkg::BYTE_RST;
            stb_q      <= status_pkg::BYTE_RST;
            opc_pend_q <= 1'b0;
            ready_q    <= 1'b1;
            reply_q    <= 1'b0;
            srq_q      <= 1'b0;
            ist_q      <= 1'b0;
            rsp_q      <= '0;
        end else begin
            state_q    <= state_d;
            esr_q      <= esr_d;
            ese_q      <= ese_d;
            sre_q      <= sre_d;
            ppe_q      <= ppe_d;
            stb_q      <= stb_d;
            opc_pend_q <= opc_pend_d;
            ready_q    <= ready_d;
            reply_q    <= reply_d;
            srq_q      <= srq_d;
            ist_q      <= ist_d;
            rsp_q      <= rsp_d;
        end
    end

    assign reg_rsp   = rsp_q;
    assign cmd_ready = ready_q;
    assign opc_reply = reply_q;
    assign srq       = srq_q;
    assign ist       = ist_q;

    sequence s_opcq_taken;
        cmd.valid && ready_q && cmd.kind == status_pkg::CMD_OPC_QUERY;
    endsequence
    sequence s_wait_taken;
        cmd.valid && ready_q && cmd.kind == status_pkg::CMD_WAIT;
    endsequence

    a_msb_zero: assert property (reg_rsp.ack |-> reg_rsp.rdata[15] == 1'b0)
        else $error("bit 15 read as one");
    a_oper_summary: assert property (1 |=> stb_q[status_pkg::STB_OPER]
                                          == $past(|(ev_q[0] & mask_q[0])))
        else $error("operation summary missing from status byte");
    a_mav_follow: assert property (1 |=> stb_q[status_pkg::STB_MAV] == $past(msg_avail))
        else $error("message available bit wrong");
    a_srq_edge: assert property (srq |-> ($past(sre_q) & status_pkg::SRE_USE
                                          & stb_q & ~$past(stb_q)) != 8'h00)
        else $error("service request without enabled rise");
    a_ist_or: assert property (1 |=> ist == |(stb_q & $past(ppe_q)))
        else $error("individual status flag wrong");
    a_opcq_reply: assert property (s_opcq_taken ##1 exec_idle |=> opc_reply
                                   && esr_q[status_pkg::ESR_OPC_BIT])
        else $error("completion query not answered");
    a_opcq_hold: assert property (s_opcq_taken ##1 !exec_idle |=> !cmd_ready && !opc_reply)
        else $error("completion query answered too early");
    a_wai_hold: assert property (s_wait_taken |=> !cmd_ready
                                 ##1 ($past(exec_idle) || !cmd_ready))
        else $error("wait command let a command through");
endmodule : status_event_hierarchy
`default_nettype wire

// [verif/exec_model.sv]
// behavioural command executor that stands behind the status block
// assumes cmd and cmd_ready run on the same clock as the block
`default_nettype none
module exec_model #(
    parameter int BUSY = 20                       // cycles a plain command keeps running
) (
    input  wire logic                 clk,        // bench clock
    input  wire logic                 resetn,     // async reset, active low
    input  wire status_pkg::cmd_req_t cmd,        // offered command
    input  wire logic                 cmd_ready,  // block takes offers
    output logic                      exec_idle   // nothing left running
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;                                    // cycles still to run
    // a plain command restarts the busy span; sync commands add no work of their own
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn)
            cnt_q <= 0;
        else if (cmd.valid && cmd_ready && cmd.kind == status_pkg::CMD_PLAIN)
            cnt_q <= BUSY;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
    assign exec_idle = (cnt_q == 0);
endmodule : exec_model
`default_nettype wire

// [verif/testbench.sv]
// self-checking bench for the status event hierarchy
// assumes exec_model plays the executor; inputs move 2 ns after each rising edge
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, err_ne = 0, mav = 0, exec_idle, cmd_ready, opc_reply, srq, ist;
    status_pkg::reg_req_t req = '0;               // register access
    status_pkg::reg_rsp_t rsp;                    // register answer
    status_pkg::cmd_req_t cmd = '0;               // command offer
    logic [14:0] oper = '0;                       // operation levels
    logic [14:0] ques = '0;                       // questionable levels
    logic [15:0] r;                               // last read data
    int fail_count = 0, checks_done = 0, srq_n = 0, rep_n = 0;
    always #12.5 clk = ~clk;                      // 40 MHz
    status_event_hierarchy i_dut (.clk(clk), .resetn(resetn), .reg_req(req), .reg_rsp(rsp),
        .oper_hw(oper), .ques_hw(ques), .esr_evt(7'h00), .err_nonempty(err_ne),
        .msg_avail(mav), .exec_idle(exec_idle), .cmd(cmd), .cmd_ready(cmd_ready),
        .opc_reply(opc_reply), .srq(srq), .ist(ist));
    exec_model i_exec (.clk(clk), .resetn(resetn), .cmd(cmd), .cmd_ready(cmd_ready),
        .exec_idle(exec_idle));
    // pulses are counted so a missing or doubled one shows up
    always @(posedge clk) begin
        if (srq === 1'b1) srq_n++;
        if (opc_reply === 1'b1) rep_n++;
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1
    // one access: strobe for a cycle, take the answer with ack
    task automatic acc(input logic w, input logic [1:0] s, input logic [2:0] p,
                       input logic [15:0] d);
        req = '{1'b1, w, s, p, d};
        @(posedge clk);
        #2;
        req.valid = 1'b0;
        r = rsp.rdata;
        chk1(rsp.ack, 1'b1);
        step(1);
    endtask : acc
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    // offer a command and hold it until an edge takes it
    task automatic issue(input status_pkg::cmd_kind_t k);
        int n;
        n = 0;
        step(1);
        cmd = '{1'b1, k};
        while (cmd_ready !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        step(1);
        cmd.valid = 1'b0;
    endtask : issue
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (3000) @(posedge clk);
        fail_count++;
        summarize;
    end
    initial begin
        step(5);
        resetn = 1'b1;
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_MASK, 16'h0);    chk16(r, 16'h0);
        acc(1, status_pkg::SEL_OPER, status_pkg::PART_RISE, 16'hffff);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_RISE, 16'h0);    chk16(r, 16'h7fff);
        acc(1, status_pkg::SEL_OPER, status_pkg::PART_LEVEL, 16'hffff);
        oper = 15'h0008;
        step(4);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_LEVEL, 16'h0);   chk16(r, 16'h0008);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);   chk16(r, 16'h0008);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);   chk16(r, 16'h0);
        oper = 15'h0000;
        step(4);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);   chk16(r, 16'h0);
        acc(1, status_pkg::SEL_OPER, status_pkg::PART_FALL, 16'h0008);
        oper = 15'h0008;
        step(4);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);
        oper = 15'h0000;
        step(4);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);   chk16(r, 16'h0008);
        $display("test edge filters done");
        acc(1, status_pkg::SEL_COMMON, status_pkg::PART_SRE, 16'h0080);
        acc(1, status_pkg::SEL_OPER, status_pkg::PART_MASK, 16'h0008);
        srq_n = 0;
        oper = 15'h0008;
        step(6);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_STB, 16'h0);   chk16(r, 16'h00c0);
        chk16(16'(srq_n), 16'h0001);
        acc(1, status_pkg::SEL_COMMON, status_pkg::PART_PPE, 16'h0010);
        mav = 1'b1;
        step(3);
        chk1(ist, 1'b1);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_STB, 16'h0);   chk16(r, 16'h00d0);
        acc(0, status_pkg::SEL_OPER, status_pkg::PART_EVENT, 16'h0);
        mav = 1'b0;
        $display("test summary chain done");
        acc(1, status_pkg::SEL_COMMON, status_pkg::PART_ESE, 16'h0001);
        acc(1, status_pkg::SEL_COMMON, status_pkg::PART_SRE, 16'h0020);
        step(4);
        srq_n = 0;
        issue(status_pkg::CMD_PLAIN);
        chk1(cmd_ready, 1'b1);
        issue(status_pkg::CMD_OPC);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_ESR, 16'h0);   chk16(r, 16'h0);
        step(30);
        chk16(16'(srq_n), 16'h0001);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_ESR, 16'h0);   chk16(r, 16'h0001);
        $display("test operation complete done");
        rep_n = 0;
        issue(status_pkg::CMD_PLAIN);
        issue(status_pkg::CMD_WAIT);
        chk1(cmd_ready, 1'b0);
        issue(status_pkg::CMD_PLAIN);
        issue(status_pkg::CMD_OPC_QUERY);
        chk1(cmd_ready, 1'b0);
        chk1(opc_reply, 1'b0);
        step(30);
        chk16(16'(rep_n), 16'h0001);
        issue(status_pkg::CMD_OPC_QUERY);
        step(2);
        chk16(16'(rep_n), 16'h0002);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_ESR, 16'h0);   chk16(r, 16'h0001);
        $display("test wait and query done");
        err_ne = 1'b1;
        acc(1, status_pkg::SEL_QUES, status_pkg::PART_RISE, 16'h0001);
        acc(1, status_pkg::SEL_QUES, status_pkg::PART_MASK, 16'h0001);
        ques = 15'h0001;
        step(4);
        acc(0, status_pkg::SEL_COMMON, status_pkg::PART_STB, 16'h0);   chk16(r, 16'h000c);
        acc(0, status_pkg::SEL_QUES, status_pkg::PART_EVENT, 16'h0);   chk16(r, 16'h0001);
        $display("test questionable and error done");
        summarize;
    end
endmodule : testbench
`default_nettype wire
